// ==== pfsws_defines.vh ====
// Constants shared by the program flash self-write sequencer
`ifndef PFSWS_DEFINES_VH
`define PFSWS_DEFINES_VH

// Core register select codes on the special-function write port
`define PFSWS_SEL_ADDR_LOW 3'h0
`define PFSWS_SEL_ADDR_HIGH 3'h1
`define PFSWS_SEL_DATA_LOW 3'h2
`define PFSWS_SEL_DATA_HIGH 3'h3
`define PFSWS_SEL_CONTROL 3'h4
`define PFSWS_SEL_UNLOCK 3'h5

// Bit positions inside nvm_control
`define PFSWS_CTL_RD 0
`define PFSWS_CTL_WR 1
`define PFSWS_CTL_WRITE_ENABLE_BIT 2
`define PFSWS_CTL_WRITE_ERROR_FLAG 3
`define PFSWS_CTL_FREE 4
`define PFSWS_CTL_LATCH_LOAD_ONLY 5
`define PFSWS_CTL_CONFIG_SPACE_SELECT 6
`define PFSWS_CTL_PROGRAM_MEMORY_SELECT 7

// Control reset value and the part that survives a warm reset
`define PFSWS_CTL_RESET 8'h00
`define PFSWS_CTL_KEEP_MASK 8'h08
`define PFSWS_CTL_WRITE_ERROR_FLAG_MASK 8'h08

// Unlock keys and unlock progress codes
`define PFSWS_UNLOCK_KEY1 8'h55
`define PFSWS_UNLOCK_KEY2 8'haa
`define PFSWS_UNL_NONE 2'h0
`define PFSWS_UNL_GOT1 2'h1
`define PFSWS_UNL_ARMED 2'h2

// Row and latch geometry: 32 words, aligned on low address bits 4:0
`define PFSWS_ROW_IDX_W 5
`define PFSWS_ROW_LAST 5'h1f
`define PFSWS_ROW_ZERO 5'h00
`define PFSWS_ROW_WORDS 32
`define PFSWS_LATCH_BLANK 14'h3fff

// Write-protect field codes and protected-region upper bounds
`define PFSWS_WP_NONE 2'h3
`define PFSWS_WP_LOW 2'h2
`define PFSWS_WP_HALF 2'h1
`define PFSWS_WP_END_LOW 15'h0200
`define PFSWS_WP_END_HALF 15'h2000
`define PFSWS_WP_END_ALL 15'h4000

// Timing: clock rate in MHz and operation times in microseconds
`define PFSWS_CLK_MHZ 125
`define PFSWS_T_ERASE_US 2000
`define PFSWS_T_PROG_US 2000
`define PFSWS_SETUP_CYC 20'h00002
`define PFSWS_CNT_ONE 20'h00001
`define PFSWS_CNT_ZERO 20'h00000
`define PFSWS_IDX_ONE 5'h01
// Default stall lengths: 2000 us each at 125 MHz, sized to the counter
`define PFSWS_ERASE_CYC_DEF 20'h3d090
`define PFSWS_PROG_CYC_DEF 20'h3d090

`endif

// ==== pfsws_latches.v ====
// Bank of 32 program-flash write latches, 14 bits each
`include "pfsws_defines.vh"

module pfsws_latches (
  input wire clk,
  input wire rst_n,
  input wire load_en,
  input wire [4:0] load_idx,
  input wire [13:0] load_data,
  input wire clear_all,
  input wire [4:0] rd_idx,
  output wire [13:0] rd_data
);

  reg [13:0] latch_mem [0:`PFSWS_ROW_WORDS-1];
  integer i;

  // Blank value on reset and after each programming pass
  always @(posedge clk) begin
    if (!rst_n || clear_all) begin
      for (i = 0; i < `PFSWS_ROW_WORDS; i = i + 1) begin
        latch_mem[i] <= `PFSWS_LATCH_BLANK; // [RQ19]
      end
    end else if (load_en) begin
      latch_mem[load_idx] <= load_data;
    end
  end

  // Plain read port; the top registers what it sends out
  assign rd_data = latch_mem[rd_idx];

endmodule // pfsws_latches

// ==== pfsws_sequencer.v ====
// Program flash self-write sequencer: reads, row erase, latch programming
`include "pfsws_defines.vh"

////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1: Software loads address, clears config select, sets program select, then reads.
// RQ2: Second instruction cycle after the read trigger fetches flash; it is ignored.
// RQ3: Read word lands in data registers next cycle and stays until replaced.
// RQ4: Software puts two no-operations after the read trigger.
// RQ5: Program flash reads work regardless of code protection.
// RQ6: Erase acts on whole 32-word rows, low five address bits zero.
// RQ7: Software sets address, selects, erase, write enable, unlocks, then triggers.
// RQ8: Write trigger only acts after 55h then AAh to the unlock port.
// RQ9: Erase-select bit clears when the row erase has finished.
// RQ10: Two setup cycles follow the write trigger; software places two no-operations.
// RQ11: Row erase halts instruction execution about 2 ms; clocks keep running.
// RQ12: After a stall execution resumes at the third instruction after trigger.
// RQ13: Programming never erases; target words must already be blank.
// RQ14: One programming pass writes all 32 row-aligned latches, never crossing rows.
// RQ15: With latch-load-only set, an unlocked trigger just loads one latch.
// RQ16: Latch loads with latch-load-only set do not stall execution.
// RQ17: With latch-load-only clear, trigger loads last latch and programs whole block.
// RQ18: Block programming halts execution about 2 ms during the final word only.
// RQ19: After programming every write latch holds 3FFFh.
// RQ20: Software increments address per load and clears latch-load-only before last.
// RQ21: Read and write triggers are set by software, cleared only by hardware.
// RQ22: Write trigger cannot set unless write enable is already set.
// RQ23: Erase or program only happens outside write-protected segments.
// RQ24: A reset during a write sets the write-error flag; the code sets it on warm reset only, a power-on reset clears it.
// RQ25: Any other register write between unlock and trigger cancels the unlock.
module pfsws_sequencer #(
  parameter [19:0] ERASE_CYCLES = `PFSWS_ERASE_CYC_DEF,
  parameter [19:0] PROG_CYCLES = `PFSWS_PROG_CYC_DEF
) (
  input wire clk,
  input wire rst_n,
  input wire por_n,
  input wire sfr_wr,
  input wire [2:0] sfr_sel,
  input wire [7:0] sfr_wdata,
  input wire [1:0] write_protect_field,
  input wire [13:0] flash_rdata,
  output reg [7:0] nvm_addr_low_r,
  output reg [6:0] nvm_addr_high_r,
  output reg [7:0] nvm_data_low_r,
  output reg [5:0] nvm_data_high_r,
  output reg [7:0] nvm_control_r,
  output reg core_stall_r,
  output reg core_ignore_r,
  output reg flash_rd_r,
  output reg flash_erase_r,
  output reg flash_pw_r,
  output reg [14:0] flash_addr_r,
  output reg [13:0] flash_wdata_r
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD_FETCH = 3'h1;
  localparam [2:0] ST_RD_DONE = 3'h2;
  localparam [2:0] ST_SETUP = 3'h3;
  localparam [2:0] ST_XFER = 3'h4;
  localparam [2:0] ST_WAIT = 3'h5;
  localparam [2:0] ST_LOAD_DONE = 3'h6;

  // Write-protect decode: true when the address sits in a locked segment
  function wp_blocks;
    input [14:0] a;
    input [1:0] f;
    begin
      case (f)
        `PFSWS_WP_NONE: wp_blocks = 1'b0;
        `PFSWS_WP_LOW: wp_blocks = (a < `PFSWS_WP_END_LOW);
        `PFSWS_WP_HALF: wp_blocks = (a < `PFSWS_WP_END_HALF);
        default: wp_blocks = (a < `PFSWS_WP_END_ALL);
      endcase
    end
  endfunction

  // Row base of an address: low five bits forced to zero
  function [14:0] row_base;
    input [14:0] a;
    begin
      row_base = {a[14:`PFSWS_ROW_IDX_W], `PFSWS_ROW_ZERO};
    end
  endfunction

  reg [2:0] state_r, state_nxt;
  reg [1:0] unlock_r, unlock_nxt;
  reg [19:0] cnt_r, cnt_nxt;
  reg [4:0] idx_r, idx_nxt;
  reg erase_op_r, erase_op_nxt;
  reg [7:0] ctl_nxt;
  reg [7:0] dlo_nxt;
  reg [5:0] dhi_nxt;
  reg stall_nxt, ignore_nxt, frd_nxt, fer_nxt, fpw_nxt;
  reg [14:0] faddr_nxt;
  reg [13:0] fwdata_nxt;
  reg lat_we, lat_clr;
  wire [13:0] lat_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Decode of core writes and trigger qualification

  wire [14:0] addr = {nvm_addr_high_r, nvm_addr_low_r};
  wire idle = (state_r == ST_IDLE);
  wire wr_ctl = sfr_wr && (sfr_sel == `PFSWS_SEL_CONTROL);
  wire wr_unl = sfr_wr && (sfr_sel == `PFSWS_SEL_UNLOCK);
  // Program space only: config space and data EEPROM are not handled here
  wire pgm_space = nvm_control_r[`PFSWS_CTL_PROGRAM_MEMORY_SELECT] &
                   ~nvm_control_r[`PFSWS_CTL_CONFIG_SPACE_SELECT]; // [RQ1] [RQ7]
  // Code protection is deliberately not consulted for reads
  wire rd_go = idle && wr_ctl && sfr_wdata[`PFSWS_CTL_RD] &&
               pgm_space; // [RQ5] [RQ21]
  // Trigger needs write enable already set and a fresh unlock
  wire wr_go = idle && wr_ctl && sfr_wdata[`PFSWS_CTL_WR] &&
               nvm_control_r[`PFSWS_CTL_WRITE_ENABLE_BIT] && // [RQ22]
               (unlock_r == `PFSWS_UNL_ARMED) && pgm_space; // [RQ8]
  wire is_erase = nvm_control_r[`PFSWS_CTL_FREE];
  wire is_latch_load_only = nvm_control_r[`PFSWS_CTL_LATCH_LOAD_ONLY];
  wire wp_hit = wp_blocks(addr, write_protect_field); // [RQ23]

  ////////////////////////////////////////////////////////////////////////
  // Unlock tracker: 55h then AAh, any other write throws it away

  always @* begin
    unlock_nxt = unlock_r;
    if (wr_unl) begin
      if (sfr_wdata == `PFSWS_UNLOCK_KEY1) begin
        unlock_nxt = `PFSWS_UNL_GOT1; // [RQ8]
      end else if (sfr_wdata == `PFSWS_UNLOCK_KEY2 &&
                   unlock_r == `PFSWS_UNL_GOT1) begin
        unlock_nxt = `PFSWS_UNL_ARMED; // [RQ8]
      end else begin
        unlock_nxt = `PFSWS_UNL_NONE;
      end
    end else if (sfr_wr) begin
      // The trigger write itself also consumes the unlock
      unlock_nxt = `PFSWS_UNL_NONE; // [RQ25]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next-state logic

  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    erase_op_nxt = erase_op_r;
    ctl_nxt = nvm_control_r;
    dlo_nxt = nvm_data_low_r;
    dhi_nxt = nvm_data_high_r;
    stall_nxt = core_stall_r;
    ignore_nxt = 1'b0;
    frd_nxt = 1'b0;
    fer_nxt = 1'b0;
    fpw_nxt = 1'b0;
    faddr_nxt = flash_addr_r;
    fwdata_nxt = flash_wdata_r;
    lat_we = 1'b0;
    lat_clr = 1'b0;
    // Software may rewrite the data pair; a read capture overrides it
    if (sfr_wr && sfr_sel == `PFSWS_SEL_DATA_LOW) begin
      dlo_nxt = sfr_wdata;
    end
    if (sfr_wr && sfr_sel == `PFSWS_SEL_DATA_HIGH) begin
      dhi_nxt = sfr_wdata[5:0];
    end
    // Control writes only land while idle; triggers cannot be cleared
    if (wr_ctl && idle) begin
      ctl_nxt = sfr_wdata;
      ctl_nxt[`PFSWS_CTL_RD] = rd_go; // [RQ21]
      ctl_nxt[`PFSWS_CTL_WR] = wr_go; // [RQ21] [RQ22]
    end
    case (state_r)
      ST_IDLE: begin
        if (rd_go) begin
          frd_nxt = 1'b1;
          faddr_nxt = addr;
          state_nxt = ST_RD_FETCH;
        end else if (wr_go && is_erase) begin
          if (wp_hit) begin
            state_nxt = ST_LOAD_DONE; // [RQ23]
          end else begin
            erase_op_nxt = 1'b1;
            stall_nxt = 1'b1; // [RQ10] [RQ11]
            cnt_nxt = `PFSWS_SETUP_CYC;
            state_nxt = ST_SETUP;
          end
        end else if (wr_go) begin
          // Every trigger loads the latch picked by the low address bits
          lat_we = 1'b1; // [RQ15] [RQ17] [RQ20]
          if (is_latch_load_only || wp_hit) begin
            state_nxt = ST_LOAD_DONE; // [RQ16] [RQ23]
          end else begin
            erase_op_nxt = 1'b0;
            stall_nxt = 1'b1; // [RQ10] [RQ18]
            cnt_nxt = `PFSWS_SETUP_CYC;
            state_nxt = ST_SETUP;
          end
        end
      end
      ST_RD_FETCH: begin
        // Flash is busy this slot, so the core drops that instruction
        ignore_nxt = 1'b1; // [RQ2] [RQ4]
        state_nxt = ST_RD_DONE;
      end
      ST_RD_DONE: begin
        dlo_nxt = flash_rdata[7:0]; // [RQ3]
        dhi_nxt = flash_rdata[13:8]; // [RQ3]
        ctl_nxt[`PFSWS_CTL_RD] = 1'b0; // [RQ21]
        state_nxt = ST_IDLE;
      end
      ST_SETUP: begin
        cnt_nxt = cnt_r - `PFSWS_CNT_ONE;
        if (cnt_r == `PFSWS_CNT_ONE) begin // [RQ10]
          if (erase_op_r) begin
            // Whole row only, whatever the low address bits hold
            fer_nxt = 1'b1; // [RQ6]
            faddr_nxt = row_base(addr); // [RQ6]
            cnt_nxt = ERASE_CYCLES; // [RQ11]
            state_nxt = ST_WAIT;
          end else begin
            idx_nxt = `PFSWS_ROW_ZERO;
            state_nxt = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        // All 32 latches go out, loaded or not, inside one row; no erase
        fpw_nxt = 1'b1; // [RQ13] [RQ14] [RQ17]
        faddr_nxt = row_base(addr) | {10'h000, idx_r}; // [RQ14]
        fwdata_nxt = lat_rdata;
        idx_nxt = idx_r + `PFSWS_IDX_ONE;
        if (idx_r == `PFSWS_ROW_LAST) begin
          cnt_nxt = PROG_CYCLES; // [RQ18]
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        cnt_nxt = cnt_r - `PFSWS_CNT_ONE;
        if (cnt_r == `PFSWS_CNT_ONE) begin
          ctl_nxt[`PFSWS_CTL_WR] = 1'b0; // [RQ21]
          if (erase_op_r) begin
            ctl_nxt[`PFSWS_CTL_FREE] = 1'b0; // [RQ9]
          end else begin
            lat_clr = 1'b1; // [RQ19]
          end
          // Release lets the core go on at the third instruction
          stall_nxt = 1'b0; // [RQ12]
          state_nxt = ST_IDLE;
        end
      end
      ST_LOAD_DONE: begin
        ctl_nxt[`PFSWS_CTL_WR] = 1'b0; // [RQ15] [RQ21]
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers: power-on clears all, warm reset keeps the error flag

  always @(posedge clk) begin
    if (!por_n || !rst_n) begin
      state_r <= ST_IDLE;
      unlock_r <= `PFSWS_UNL_NONE;
      cnt_r <= `PFSWS_CNT_ZERO;
      idx_r <= `PFSWS_ROW_ZERO;
      erase_op_r <= 1'b0;
      nvm_addr_low_r <= 8'h00;
      nvm_addr_high_r <= 7'h00;
      nvm_data_low_r <= 8'h00;
      nvm_data_high_r <= 6'h00;
      core_stall_r <= 1'b0;
      core_ignore_r <= 1'b0;
      flash_rd_r <= 1'b0;
      flash_erase_r <= 1'b0;
      flash_pw_r <= 1'b0;
      flash_addr_r <= 15'h0000;
      flash_wdata_r <= 14'h0000;
      if (!por_n) begin
        nvm_control_r <= `PFSWS_CTL_RESET;
      end else begin
        // A write cut short by reset leaves a flag for software
        nvm_control_r <= (nvm_control_r & `PFSWS_CTL_KEEP_MASK) |
                         (nvm_control_r[`PFSWS_CTL_WR] ?
                          `PFSWS_CTL_WRITE_ERROR_FLAG_MASK :
                          `PFSWS_CTL_RESET); // [RQ24]
      end
    end else begin
      state_r <= state_nxt;
      unlock_r <= unlock_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      erase_op_r <= erase_op_nxt;
      nvm_control_r <= ctl_nxt;
      nvm_data_low_r <= dlo_nxt;
      nvm_data_high_r <= dhi_nxt;
      core_stall_r <= stall_nxt;
      core_ignore_r <= ignore_nxt;
      flash_rd_r <= frd_nxt;
      flash_erase_r <= fer_nxt;
      flash_pw_r <= fpw_nxt;
      flash_addr_r <= faddr_nxt;
      flash_wdata_r <= fwdata_nxt;
      // Address pair is plain storage; the core is stalled while it matters
      if (sfr_wr && sfr_sel == `PFSWS_SEL_ADDR_LOW) begin
        nvm_addr_low_r <= sfr_wdata;
      end
      if (sfr_wr && sfr_sel == `PFSWS_SEL_ADDR_HIGH) begin
        nvm_addr_high_r <= sfr_wdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write latch bank

  pfsws_latches u_latches (
    .clk(clk),
    .rst_n(rst_n),
    .load_en(lat_we),
    .load_idx(nvm_addr_low_r[4:0]),
    .load_data({nvm_data_high_r, nvm_data_low_r}),
    .clear_all(lat_clr),
    .rd_idx(idx_r),
    .rd_data(lat_rdata)
  );

endmodule // pfsws_sequencer

// ==== pfsws_props.sv ====
// Port-level checks for the program flash self-write sequencer
module pfsws_props #(
  parameter int ERASE_CYCLES = 20
) (
  input wire clk,
  input wire rst_n,
  input wire por_n,
  input wire sfr_wr,
  input wire [2:0] sfr_sel,
  input wire [7:0] sfr_wdata,
  input wire [1:0] write_protect_field,
  input wire [7:0] nvm_control_r,
  input wire core_stall_r,
  input wire core_ignore_r,
  input wire flash_rd_r,
  input wire flash_erase_r,
  input wire flash_pw_r,
  input wire [14:0] flash_addr_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] arm_r;
  logic [5:0] pw_cnt_r;
  logic [14:0] lim;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !por_n);
  ////////////////////////////////////////
  // Shadow of the unlock state; any stray write disarms it
  always @(posedge clk) begin
    if (!rst_n || !por_n) arm_r <= 2'h0;
    else if (sfr_wr) arm_r <= (sfr_sel == 3'h5 && sfr_wdata == 8'h55) ? 2'h1 :
      (sfr_sel == 3'h5 && sfr_wdata == 8'haa && arm_r == 2'h1) ? 2'h2 : 2'h0;
  end
  // Counts word pulses of the running burst, so index checks need no state
  always @(posedge clk) begin
    if (!rst_n || !por_n || !flash_pw_r) pw_cnt_r <= 6'h00;
    else pw_cnt_r <= pw_cnt_r + 6'h01;
  end
  // Top of the protected region for each protect code
  assign lim = write_protect_field == 2'h2 ? 15'h0200 :
    write_protect_field == 2'h1 ? 15'h2000 : 15'h4000;
  ////////////////////////////////////////
  a_read_ignore_slot: assert property (
    $rose(flash_rd_r) |=> core_ignore_r && !flash_rd_r)
    else $error("no discard pulse after flash fetch");
  a_read_trig_clear: assert property (
    flash_rd_r |-> ##2 !nvm_control_r[0])
    else $error("read trigger not cleared after capture");
  a_wr_needs_write_enable_bit: assert property (
    $rose(nvm_control_r[1]) |-> $past(nvm_control_r[2]))
    else $error("write trigger set without write enable");
  a_wr_needs_unlock: assert property (
    sfr_wr && sfr_sel == 3'h4 && arm_r != 2'h2 && nvm_control_r[1:0] == 2'h0
    |=> !nvm_control_r[1])
    else $error("write trigger set without unlock");
  a_erase_setup_row: assert property (
    flash_erase_r |-> core_stall_r && $past(core_stall_r, 2)
      && !$past(core_stall_r, 3) && flash_addr_r[4:0] == 5'h00)
    else $error("erase pulse timing or row base wrong");
  a_erase_stall_len: assert property (
    flash_erase_r |-> ##ERASE_CYCLES !core_stall_r && $past(core_stall_r)
      && !nvm_control_r[4])
    else $error("erase stall length wrong");
  a_stall_end_wr: assert property (
    $fell(core_stall_r) |-> $fell(nvm_control_r[1]))
    else $error("stall and write trigger end apart");
  a_latch_no_stall: assert property (
    $rose(nvm_control_r[1]) && nvm_control_r[5] |-> !core_stall_r
      ##1 !nvm_control_r[1])
    else $error("latch load stalled or lingered");
  a_prog_word_count: assert property (
    $fell(flash_pw_r) |-> pw_cnt_r == 6'h20)
    else $error("burst is not 32 words");
  a_prog_word_index: assert property (
    flash_pw_r |-> flash_addr_r[4:0] == pw_cnt_r[4:0])
    else $error("burst word address out of order");
  a_protect_guard: assert property (
    flash_erase_r || flash_pw_r |-> write_protect_field == 2'h3
      || flash_addr_r >= lim)
    else $error("flash changed inside protected region");
endmodule // pfsws_props

// ==== pfsws_flash_model.sv ====
// Behavioural program flash array on the sequencer's far side
module pfsws_flash_model (
  input wire clk,
  input wire flash_rd_r,
  input wire flash_erase_r,
  input wire flash_pw_r,
  input wire [14:0] flash_addr_r,
  input wire [13:0] flash_wdata_r,
  output logic [13:0] flash_rdata,
  output int n_erase,
  output int n_pw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [0:32767];
  // Preload a known pattern so reads of untouched words are predictable
  initial begin
    flash_rdata = 14'h0000;
    n_erase = 0;
    n_pw = 0;
    for (int i = 0; i < 32768; i++) mem[i] = 14'(i) ^ 14'h2a5a;
  end
  // Erase blanks a whole row; programming only clears bits, never erases
  always @(posedge clk) begin
    if (flash_erase_r) begin
      for (int j = 0; j < 32; j++) mem[{flash_addr_r[14:5], 5'(j)}] = 14'h3fff;
      n_erase++;
    end
    if (flash_pw_r) begin
      mem[flash_addr_r] = mem[flash_addr_r] & flash_wdata_r;
      n_pw++;
    end
    // Word valid only the cycle after a fetch; scrambled otherwise
    flash_rdata <= flash_rd_r ? mem[flash_addr_r] : ~flash_rdata;
  end
endmodule // pfsws_flash_model

// ==== pfsws_sequencer_tb.sv ====
// Self-checking bench for the program flash self-write sequencer
module pfsws_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, por_n, sfr_wr;
  logic [2:0] sfr_sel;
  logic [7:0] sfr_wdata;
  logic [1:0] write_protect_field;
  wire [13:0] flash_rdata, flash_wdata_r;
  wire [7:0] nvm_addr_low_r, nvm_data_low_r, nvm_control_r;
  wire [6:0] nvm_addr_high_r;
  wire [5:0] nvm_data_high_r;
  wire core_stall_r, core_ignore_r, flash_rd_r, flash_erase_r, flash_pw_r;
  wire [14:0] flash_addr_r;
  int n_erase, n_pw, n_mismatch, n_tests, stall_n, e0, p0;
  // Short operation times keep the run small
  pfsws_sequencer #(.ERASE_CYCLES(20'h00014), .PROG_CYCLES(20'h00014)) uut (.*);
  pfsws_flash_model u_flash (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [13:0] pat(input logic [14:0] a);
    return a[13:0] ^ 14'h2a5a;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One strobe; the leading edge wait keeps strobes a cycle apart
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_sel = s;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
  endtask
  task automatic go(input logic [7:0] c);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'haa);
    wr(3'h4, c);
  endtask
  // Bounded wait for a control bit to drop, counting stalled cycles
  task automatic wait_clr(input int b);
    int i;
    stall_n = 0;
    for (i = 0; i < 500 && nvm_control_r[b] !== 1'b0; i++) begin
      if (core_stall_r === 1'b1) stall_n++;
      @(posedge clk);
      #1;
    end
    if (i == 500) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // Idle after the trigger stands in for the two no-operations
  task automatic rd(input logic [14:0] a, input logic [13:0] exp);
    wr(3'h1, {1'b0, a[14:8]});
    wr(3'h0, a[7:0]);
    wr(3'h4, 8'h80);
    wr(3'h4, 8'h81);
    wait_clr(0);
    chk({2'h0, nvm_data_high_r, nvm_data_low_r}, {2'h0, exp});
  endtask
  task automatic ld(input logic [7:0] a, input logic [13:0] d,
    input logic [7:0] c);
    wr(3'h0, a);
    wr(3'h2, d[7:0]);
    wr(3'h3, {2'h0, d[13:8]});
    go(c);
    wait_clr(1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_sel = 3'h0;
    sfr_wdata = 8'h00;
    write_protect_field = 2'h0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    por_n = 1'b1;
    chk(nvm_control_r, 8'h00);
    // Reads work even with every segment protected
    rd(15'h0123, pat(15'h0123));
    rd(15'h3fff, pat(15'h3fff));
    wr(3'h4, 8'h80);
    chk(nvm_data_low_r, 8'ha5);
    wr(3'h2, 8'h3c);
    chk(nvm_data_low_r, 8'h3c);
    $display("read test done");
    // Trigger refused without prior enable, and after a stray write
    write_protect_field = 2'h3;
    wr(3'h1, 8'h01);
    wr(3'h0, 8'h23);
    chk({1'b0, nvm_addr_high_r, nvm_addr_low_r}, 16'h0123);
    go(8'h96);
    chk(nvm_control_r[1], 1'b0);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'haa);
    wr(3'h0, 8'h23);
    wr(3'h4, 8'h96);
    chk(nvm_control_r[1], 1'b0);
    $display("refusal test done");
    // Row erase from a mid-row address
    e0 = n_erase;
    go(8'h96);
    chk(nvm_control_r[1], 1'b1);
    wait_clr(4);
    chk(stall_n, 16'h0016);
    chk(nvm_control_r, 8'h84);
    chk(n_erase, e0 + 1);
    rd(15'h0120, 14'h3fff);
    rd(15'h011f, pat(15'h011f));
    $display("erase test done");
    // Erase inside a protected segment does nothing
    write_protect_field = 2'h2;
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h40);
    wr(3'h4, 8'h94);
    go(8'h96);
    wait_clr(1);
    chk(n_erase, e0 + 1);
    rd(15'h0040, pat(15'h0040));
    // Lower-half protection blocks an erase at 1040h as well
    write_protect_field = 2'h1;
    wr(3'h1, 8'h10);
    wr(3'h4, 8'h94);
    go(8'h96);
    wait_clr(1);
    chk(n_erase, e0 + 1);
    $display("protect test done");
    // Two latch loads, then last latch plus block program
    write_protect_field = 2'h3;
    p0 = n_pw;
    wr(3'h1, 8'h01);
    wr(3'h4, 8'ha4);
    ld(8'h20, 14'h1234, 8'ha6);
    chk(stall_n, 16'h0000);
    ld(8'h21, 14'h0abc, 8'ha6);
    wr(3'h4, 8'h84);
    ld(8'h3f, 14'h2222, 8'h86);
    chk(n_pw, p0 + 32);
    rd(15'h0120, 14'h1234);
    rd(15'h0121, 14'h0abc);
    rd(15'h0122, 14'h3fff);
    rd(15'h013f, 14'h2222);
    // Re-erase, program last latch only: stale latches would show
    wr(3'h4, 8'h94);
    go(8'h96);
    wait_clr(4);
    ld(8'h3f, 14'h1111, 8'h86);
    rd(15'h0120, 14'h3fff);
    rd(15'h013f, 14'h1111);
    $display("program test done");
    // Warm reset in mid-erase leaves the error flag
    wr(3'h4, 8'h94);
    go(8'h96);
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(nvm_control_r, 8'h08);
    por_n = 1'b0;
    @(posedge clk);
    #1;
    por_n = 1'b1;
    chk(nvm_control_r, 8'h00);
    $display("reset test done");
    tally_and_finish();
  end
endmodule // pfsws_sequencer_tb
bind pfsws_sequencer pfsws_props #(.ERASE_CYCLES(20)) u_props (.*);
